//--- common/hsc_consts.svh
`ifndef HSC_CONSTS_SVH
`define HSC_CONSTS_SVH

// counter and preset geometry
`define HSC_CNT_W        32
`define HSC_IDX_W        3
`define HSC_MAX_PRESET   6
`define HSC_NUM_COND     8
`define HSC_OVF_BIT      6
`define HSC_UDF_BIT      7

// count limits and reset values
`define HSC_CNT_MAX      32'hffffffff
`define HSC_CNT_ZERO     32'h00000000
`define HSC_CNT_ONE      32'h00000001
`define HSC_IDX_FIRST    3'h1

// timing: least spacing between two matches, kept by the user
`define HSC_CLK_NS            20
`define HSC_MIN_MATCH_NS      1000000
`define HSC_MIN_MATCH_CYC     ((`HSC_MIN_MATCH_NS + `HSC_CLK_NS - 1) / `HSC_CLK_NS)

`endif

//--- common/hsc_pkg.sv
`default_nettype none
`include "hsc_consts.svh"

package hsc_pkg;

  typedef logic [`HSC_CNT_W-1:0] hsc_cnt_t;
  typedef logic [`HSC_IDX_W-1:0] hsc_idx_t;

  typedef enum logic [1:0] {
    HSC_ADD   = 2'h0,
    HSC_UPDN  = 2'h1,
    HSC_QUAD2 = 2'h2,
    HSC_QUAD4 = 2'h3
  } hsc_mode_e;

  typedef enum logic {
    HSC_ACT_OUTPUT = 1'b0,
    HSC_ACT_IRQ    = 1'b1
  } hsc_action_e;

  typedef enum logic [2:0] {
    HSC_PH_INIT = 3'h1,
    HSC_PH_ARM  = 3'h2,
    HSC_PH_RUN  = 3'h4
  } hsc_phase_e;

  typedef struct packed {
    hsc_mode_e   mode;
    hsc_action_e action;
    hsc_idx_t    preset_count;
    logic        keep;
    logic        ovf_en;
    logic        udf_en;
    logic        clear_en;
  } hsc_cfg_s;

  typedef struct packed {
    logic gate;
    logic sw_reset;
    logic out_reset;
  } hsc_ctrl_s;

  typedef struct packed {
    logic     wr;
    hsc_idx_t sel;
    hsc_cnt_t data;
  } hsc_wr_s;

  typedef struct packed {
    logic match;
    logic ovf;
    logic udf;
    logic rst;
  } hsc_flags_s;

  typedef struct packed {
    logic step;
    logic up;
    logic clear;
  } hsc_step_s;

  typedef struct packed {
    logic [2:0] sync1;
    logic [2:0] sync2;
    logic [2:0] prev;
  } hsc_dec_state_s;

  typedef struct packed {
    hsc_phase_e                       phase;
    hsc_cnt_t                         cnt;
    hsc_cnt_t                         cnt_shadow;
    hsc_cnt_t                         active_preset;
    hsc_cnt_t                         preset_rd;
    hsc_cnt_t [`HSC_MAX_PRESET-1:0]   presets;
    hsc_idx_t                         active_idx;
    hsc_idx_t                         next_idx;
    hsc_flags_s                       pend;
    hsc_flags_s                       flags;
    logic                             dir_up;
    logic [`HSC_NUM_COND-1:0]         cmp_out;
    logic                             irq;
  } hsc_state_s;

endpackage
`default_nettype wire

//--- src/hsc_counter.sv
// Summary of operation
// R01: on a match the queued preset index becomes active and counting goes on.
// R02: after promotion on a match the queued index steps up by one.
// R03: after the last preset matches, comparison restarts with preset one.
// R04: one to six presets, numbered one to six, are configurable.
// R05: with a single preset the queued index always holds one.
// R06: queued index is one in the first scan; second scan end copies it active.
// R07: active index is read-only; queued index and preset values are read/write.
// R08: software changes the queued index before that preset becomes active.
// R09: a preset rewritten before its match is reloaded at the end of scan.
// R10: matches should be at least 1 ms apart or a match flag may merge.
// R11: adding mode counts up on each pulse rising edge.
// R12: up/down mode counts on pulse rising edge, direction input picks sense.
// R13: 2-edge quadrature counts on both b edges, up when a leads.
// R14: 4-edge quadrature counts on every a and b edge, up when a leads.
// R15: only dual-capable groups offer up/down and quadrature; others add only.
// R16: a trigger either sets a compare output or pulses an interrupt request.
// R17: overflow and underflow act as extra triggers when enabled.
// R18: each trigger condition owns its own compare output.
// R19: after a match the count reloads the reset value unless keep is set.
// R20: an enabled external clear loads the reset value; groups one and three only.
// R21: the match flag stands for exactly one scan.
// R22: counting proceeds only while the gate is on.
// R23: published count and status flags refresh once per scan.
// R24: overflow wraps to zero, underflow to all ones; each flags one scan.
// R25: pulse, direction and phase inputs are synchronised before edge detection.
`timescale 1ns/1ps
`default_nettype none
`include "hsc_consts.svh"

module hsc_counter #(
  parameter int N_PRESET = `HSC_MAX_PRESET,
  parameter bit DUAL_CAP = 1'b1
) (
  input  wire logic                 core_clk_i,
  input  wire logic                 rstn_i,
  input  wire logic                 clk_en_i,
  input  wire logic                 pulse_a_i,
  input  wire logic                 pulse_b_i,
  input  wire logic                 group_clear_input_i,
  input  wire logic                 scan_end_i,
  input  wire hsc_pkg::hsc_cfg_s    cfg_i,
  input  wire hsc_pkg::hsc_ctrl_s   ctrl_i,
  input  wire hsc_pkg::hsc_cnt_t    reset_value_i,
  input  wire hsc_pkg::hsc_wr_s     preset_wr_i,
  input  wire logic                 next_wr_i,
  input  wire hsc_pkg::hsc_idx_t    next_data_i,
  input  wire hsc_pkg::hsc_idx_t    preset_rd_sel_i,
  output hsc_pkg::hsc_cnt_t         count_o,
  output hsc_pkg::hsc_idx_t         active_idx_o,
  output hsc_pkg::hsc_idx_t         next_idx_o,
  output logic [15:0]               active_preset_upper_word_o,
  output logic [15:0]               active_preset_lower_word_o,
  output hsc_pkg::hsc_cnt_t         preset_rd_o,
  output hsc_pkg::hsc_flags_s       flags_o,
  output logic                      dir_up_o,
  output logic [`HSC_NUM_COND-1:0]  cmp_out_o,
  output logic                      irq_o,
  output logic                      first_scan_init_pulse_o
);
  import hsc_pkg::*;

  localparam hsc_state_s ST_RST = '{phase: HSC_PH_INIT, default: '0};

  if (N_PRESET < 1 || N_PRESET > `HSC_MAX_PRESET) begin : g_bad_preset
    $error("hsc_counter: N_PRESET must lie in 1..6");
  end

  logic [1:0]               rst_sync_reg;
  logic                     rst_n;
  hsc_state_s               st_reg;
  hsc_state_s               st_next;
  hsc_step_s                dec;
  hsc_mode_e                eff_mode;
  hsc_idx_t                 eff_count;
  hsc_flags_s               ev;
  logic [`HSC_NUM_COND-1:0] trig;
  logic                     step_go;
  logic                     match_ev;
  logic                     ext_clear;

  function automatic hsc_idx_t slot(input hsc_idx_t idx);
    slot = idx - `HSC_IDX_FIRST;
  endfunction

  function automatic logic idx_ok(input hsc_idx_t idx, input hsc_idx_t lim);
    idx_ok = (idx >= `HSC_IDX_FIRST) && (idx <= lim);
  endfunction

  function automatic hsc_idx_t next_after(input hsc_idx_t idx, input hsc_idx_t lim);
    next_after = (idx >= lim) ? `HSC_IDX_FIRST : idx + `HSC_IDX_FIRST;
  endfunction

  always_ff @(posedge core_clk_i or negedge rstn_i) begin
    if (!rstn_i) begin
      rst_sync_reg <= 2'h0;
    end else begin
      rst_sync_reg <= {rst_sync_reg[0], 1'b1};
    end
  end
  assign rst_n = rst_sync_reg[1];

  assign eff_mode  = DUAL_CAP ? cfg_i.mode : HSC_ADD; // R15
  assign eff_count = idx_ok(cfg_i.preset_count, hsc_idx_t'(N_PRESET)) ?
                     cfg_i.preset_count : hsc_idx_t'(N_PRESET); // R04
  assign step_go   = dec.step && ctrl_i.gate; // R22
  assign ext_clear = dec.clear && cfg_i.clear_en && DUAL_CAP; // R20

  hsc_edge_dec u_dec (
    .core_clk_i (core_clk_i),
    .rst_n_i    (rst_n),
    .clk_en_i   (clk_en_i),
    .mode_i     (eff_mode),
    .pulse_a_i  (pulse_a_i),
    .pulse_b_i  (pulse_b_i),
    .clear_i    (group_clear_input_i),
    .step_o     (dec)
  );

  always_comb begin
    st_next     = st_reg;
    st_next.irq = 1'b0;
    ev          = '0;
    trig        = '0;
    match_ev    = 1'b0;

    if (preset_wr_i.wr && idx_ok(preset_wr_i.sel, hsc_idx_t'(N_PRESET))) begin
      st_next.presets[slot(preset_wr_i.sel)] = preset_wr_i.data; // R07
    end
    st_next.preset_rd = idx_ok(preset_rd_sel_i, hsc_idx_t'(N_PRESET)) ?
                        st_reg.presets[slot(preset_rd_sel_i)] : `HSC_CNT_ZERO;
    if (next_wr_i && idx_ok(next_data_i, eff_count)) begin
      st_next.next_idx = next_data_i; // R07 R08
    end

    if (step_go) begin
      st_next.dir_up = dec.up;
      if (dec.up) begin
        st_next.cnt = st_reg.cnt + `HSC_CNT_ONE; // R11 R12 R13 R14 R24
        ev.ovf      = (st_reg.cnt == `HSC_CNT_MAX);
      end else begin
        st_next.cnt = st_reg.cnt - `HSC_CNT_ONE; // R12 R13 R14 R24
        ev.udf      = (st_reg.cnt == `HSC_CNT_ZERO);
      end
      match_ev = (st_reg.phase == HSC_PH_RUN) && (st_next.cnt == st_reg.active_preset);
    end

    if (scan_end_i) begin
      case (st_reg.phase)
        HSC_PH_INIT: begin
          st_next.phase = HSC_PH_ARM;
        end
        HSC_PH_ARM: begin
          st_next.active_idx    = st_reg.next_idx; // R06
          st_next.active_preset = st_reg.presets[slot(st_reg.next_idx)];
          st_next.next_idx      = next_after(st_reg.next_idx, eff_count);
          st_next.phase         = HSC_PH_RUN;
        end
        HSC_PH_RUN: begin
          st_next.active_preset = st_reg.presets[slot(st_reg.active_idx)]; // R09
        end
        default: begin
          st_next.phase = HSC_PH_INIT;
        end
      endcase
    end
    if (st_reg.phase == HSC_PH_INIT) begin
      st_next.next_idx = `HSC_IDX_FIRST; // R06
    end

    if (match_ev) begin
      st_next.active_idx    = st_reg.next_idx; // R01
      st_next.active_preset = st_reg.presets[slot(st_reg.next_idx)];
      st_next.next_idx      = next_after(st_reg.next_idx, eff_count); // R02 R03
      if (!cfg_i.keep) begin
        st_next.cnt = reset_value_i; // R19
      end
      ev.match = 1'b1;
      trig[slot(st_reg.active_idx)] = 1'b1; // R18
    end
    if (ev.ovf && cfg_i.ovf_en) begin
      trig[`HSC_OVF_BIT] = 1'b1; // R17 R18
    end
    if (ev.udf && cfg_i.udf_en) begin
      trig[`HSC_UDF_BIT] = 1'b1; // R17 R18
    end

    if (ctrl_i.sw_reset || ext_clear) begin
      st_next.cnt = reset_value_i; // R20
      ev.rst      = ext_clear;
    end

    if (eff_count == `HSC_IDX_FIRST) begin
      st_next.next_idx = `HSC_IDX_FIRST; // R05
    end

    if (ctrl_i.out_reset) begin
      st_next.cmp_out = '0;
    end
    if (cfg_i.action == HSC_ACT_OUTPUT) begin
      st_next.cmp_out = st_next.cmp_out | trig; // R16
    end else begin
      st_next.irq = |trig; // R16
    end

    // events land in the pending set; the scan end publishes and clears it
    if (scan_end_i) begin
      st_next.flags      = hsc_flags_s'(st_reg.pend | ev); // R21 R23 R24
      st_next.pend       = '0;
      st_next.cnt_shadow = st_next.cnt; // R23
    end else begin
      st_next.pend = hsc_flags_s'(st_reg.pend | ev);
    end
  end

  always_ff @(posedge core_clk_i or negedge rst_n) begin
    if (!rst_n) begin
      st_reg <= ST_RST;
    end else if (clk_en_i) begin
      st_reg <= st_next;
    end
  end

  assign count_o                    = st_reg.cnt_shadow;
  assign active_idx_o               = st_reg.active_idx;
  assign next_idx_o                 = st_reg.next_idx;
  assign active_preset_upper_word_o = st_reg.active_preset[31:16];
  assign active_preset_lower_word_o = st_reg.active_preset[15:0];
  assign preset_rd_o                = st_reg.preset_rd;
  assign flags_o                    = st_reg.flags;
  assign dir_up_o                   = st_reg.dir_up;
  assign cmp_out_o                  = st_reg.cmp_out;
  assign irq_o                      = st_reg.irq;
  assign first_scan_init_pulse_o    = (st_reg.phase == HSC_PH_INIT);

  logic plain_step;
  assign plain_step = clk_en_i && step_go && !match_ev && !ctrl_i.sw_reset && !ext_clear;

  default clocking cb @(posedge core_clk_i); endclocking
  default disable iff (!rst_n);

  a_match_promote: assert property (clk_en_i && match_ev |=> // R01
    st_reg.active_idx == $past(st_reg.next_idx))
    else $error("match did not promote queued index");

  a_next_step: assert property (clk_en_i && match_ev && !next_wr_i && // R02
    st_reg.next_idx < eff_count && eff_count > 3'h1 |=>
    st_reg.next_idx == $past(st_reg.next_idx) + 3'h1)
    else $error("queued index did not step by one");

  a_next_wrap: assert property (clk_en_i && match_ev && // R03
    st_reg.next_idx == eff_count |=> st_reg.next_idx == 3'h1)
    else $error("queued index did not wrap to one");

  a_single_preset: assert property ($past(clk_en_i) && // R05
    $past(eff_count == 3'h1) |-> st_reg.next_idx == 3'h1)
    else $error("single preset must keep queued index at one");

  a_arm_copy: assert property (clk_en_i && scan_end_i && // R06
    st_reg.phase == HSC_PH_ARM |=> st_reg.phase == HSC_PH_RUN &&
    st_reg.active_idx == $past(st_reg.next_idx))
    else $error("second scan end did not copy queued index");

  a_active_ro: assert property (!(clk_en_i && (match_ev || // R07
    (scan_end_i && st_reg.phase == HSC_PH_ARM))) |=> $stable(st_reg.active_idx))
    else $error("active index moved without a match");

  a_preset_reload: assert property (clk_en_i && scan_end_i && !match_ev && // R09
    st_reg.phase == HSC_PH_RUN |=>
    st_reg.active_preset == $past(st_reg.presets[slot(st_reg.active_idx)]))
    else $error("active preset not refreshed at scan end");

  a_count_plain: assert property (plain_step |=> // R11 R12 R13 R14 R24
    st_reg.cnt == ($past(dec.up) ? $past(st_reg.cnt) + `HSC_CNT_ONE :
                                   $past(st_reg.cnt) - `HSC_CNT_ONE))
    else $error("count step wrong");

  a_add_only: assert property (!DUAL_CAP |-> eff_mode == HSC_ADD) // R15
    else $error("single-only group left adding mode");

  a_irq_pulse: assert property (clk_en_i && |trig && // R16 R17
    cfg_i.action == HSC_ACT_IRQ |=> irq_o ##1 (!irq_o || $past(clk_en_i && |trig)))
    else $error("interrupt request not a single pulse");

  a_keep_reload: assert property (clk_en_i && match_ev && !cfg_i.keep && // R19
    !ctrl_i.sw_reset && !ext_clear |=> st_reg.cnt == $past(reset_value_i))
    else $error("match without keep did not reload");

  a_clear_load: assert property (clk_en_i && ext_clear |=> // R20
    st_reg.cnt == $past(reset_value_i) && st_reg.pend.rst | st_reg.flags.rst)
    else $error("external clear did not load reset value");

  a_flag_scan: assert property (clk_en_i && !scan_end_i |=> // R21 R23
    $stable(st_reg.flags) && $stable(st_reg.cnt_shadow))
    else $error("published state moved inside a scan");

  a_gate_hold: assert property (clk_en_i && !ctrl_i.gate && !ctrl_i.sw_reset && // R22
    !ext_clear |=> $stable(st_reg.cnt))
    else $error("count moved with gate off");

  a_ovf_wrap: assert property (plain_step && dec.up && // R24
    st_reg.cnt == `HSC_CNT_MAX |=> st_reg.cnt == `HSC_CNT_ZERO && st_reg.pend.ovf |
    st_reg.flags.ovf)
    else $error("overflow did not wrap to zero");

  c_match: cover property (clk_en_i && match_ev);
  c_wrap: cover property (clk_en_i && match_ev && st_reg.next_idx == eff_count);
  c_ovf: cover property (clk_en_i && ev.ovf);
  c_irq: cover property (irq_o);

endmodule
`default_nettype wire

//--- src/hsc_edge_dec.sv
`timescale 1ns/1ps
`default_nettype none
`include "hsc_consts.svh"

module hsc_edge_dec (
  input  wire logic               core_clk_i,
  input  wire logic               rst_n_i,
  input  wire logic               clk_en_i,
  input  wire hsc_pkg::hsc_mode_e mode_i,
  input  wire logic               pulse_a_i,
  input  wire logic               pulse_b_i,
  input  wire logic               clear_i,
  output hsc_pkg::hsc_step_s      step_o
);
  import hsc_pkg::*;

  hsc_dec_state_s st_reg;
  hsc_dec_state_s st_next;
  logic           a_chg;
  logic           b_chg;
  logic           a_rise;
  logic           quad_up;

  // bit 0 phase a / pulse, bit 1 phase b / direction, bit 2 clear
  always_comb begin
    st_next       = st_reg;
    st_next.sync1 = {clear_i, pulse_b_i, pulse_a_i};
    st_next.sync2 = st_reg.sync1;
    st_next.prev  = st_reg.sync2;
  end

  always_ff @(posedge core_clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      st_reg <= '0;
    end else if (clk_en_i) begin
      st_reg <= st_next; // R25
    end
  end

  // edges only from the second stage against its delayed copy
  assign a_chg   = st_reg.sync2[0] ^ st_reg.prev[0];
  assign b_chg   = st_reg.sync2[1] ^ st_reg.prev[1];
  assign a_rise  = st_reg.sync2[0] & ~st_reg.prev[0];
  assign quad_up = st_reg.sync2[0] ^ st_reg.prev[1];

  always_comb begin
    step_o.clear = st_reg.sync2[2] & ~st_reg.prev[2];
    case (mode_i)
      HSC_ADD: begin
        step_o.step = a_rise; // R11
        step_o.up   = 1'b1;
      end
      HSC_UPDN: begin
        step_o.step = a_rise; // R12
        step_o.up   = st_reg.sync2[1];
      end
      HSC_QUAD2: begin
        step_o.step = b_chg; // R13
        step_o.up   = quad_up;
      end
      HSC_QUAD4: begin
        step_o.step = a_chg | b_chg; // R14
        step_o.up   = quad_up;
      end
      default: begin
        step_o.step = 1'b0;
        step_o.up   = 1'b1;
      end
    endcase
  end

endmodule
`default_nettype wire

//--- test/hsc_pulse_src.sv
`timescale 1ns/1ps
`default_nettype none

module hsc_pulse_src (
  input  wire logic core_clk_i,
  output logic      pulse_a_o,
  output logic      pulse_b_o
);
  initial begin
    pulse_a_o = 1'b0;
    pulse_b_o = 1'b0;
  end

  // each level is held four cycles so the input synchroniser sees it
  task automatic lvl(input logic na, input logic nb);
    @(posedge core_clk_i);
    pulse_a_o <= na;
    pulse_b_o <= nb;
    repeat (3) @(posedge core_clk_i);
  endtask

  // one rising pulse on a, b carries the direction level
  task automatic single(input logic dir);
    lvl(1'b1, dir);
    lvl(1'b0, dir);
  endtask

  // one full quadrature cycle, a leading when fwd is set
  task automatic quad(input logic fwd);
    if (fwd) begin
      lvl(1'b1, 1'b0);
      lvl(1'b1, 1'b1);
      lvl(1'b0, 1'b1);
    end else begin
      lvl(1'b0, 1'b1);
      lvl(1'b1, 1'b1);
      lvl(1'b1, 1'b0);
    end
    lvl(1'b0, 1'b0);
  endtask
endmodule

`default_nettype wire

//--- test/tb_hsc_counter.sv
`timescale 1ns/1ps
`default_nettype none

module tb_hsc_counter;
  import hsc_pkg::*;
  localparam int SCAN = 100;
  typedef struct packed {
    hsc_idx_t   act;
    hsc_idx_t   nxt;
    hsc_cnt_t   cnt;
    logic [7:0] out;
  } hsc_note_s;

  logic       core_clk_i, rstn_i, clk_en_i, scan_end_i, group_clear_input_i, next_wr_i;
  logic       pulse_a, pulse_b, m_prev, dir_up_o, irq_o, first_scan_init_pulse_o;
  hsc_cfg_s   cfg_i;
  hsc_ctrl_s  ctrl_i;
  hsc_cnt_t   reset_value_i, count_o, preset_rd_o;
  hsc_wr_s    preset_wr_i;
  hsc_idx_t   next_data_i, preset_rd_sel_i, active_idx_o, next_idx_o;
  logic [15:0] up_w, lo_w;
  hsc_flags_s flags_o;
  logic [7:0] cmp_out_o;
  int         error_cnt = 0;
  int         checked = 0;
  int         irq_cnt = 0;
  int         mlen = 0;
  integer     seed = 32'h16a4a840;
  hsc_note_s  notes[$];

  hsc_pulse_src hsc_pulse_src_i (.core_clk_i(core_clk_i), .pulse_a_o(pulse_a),
                                 .pulse_b_o(pulse_b));

  hsc_counter #(.N_PRESET(6), .DUAL_CAP(1'b1)) hsc_counter_i (
    .core_clk_i(core_clk_i), .rstn_i(rstn_i), .clk_en_i(clk_en_i),
    .pulse_a_i(pulse_a), .pulse_b_i(pulse_b), .group_clear_input_i(group_clear_input_i),
    .scan_end_i(scan_end_i), .cfg_i(cfg_i), .ctrl_i(ctrl_i), .reset_value_i(reset_value_i),
    .preset_wr_i(preset_wr_i), .next_wr_i(next_wr_i), .next_data_i(next_data_i),
    .preset_rd_sel_i(preset_rd_sel_i), .count_o(count_o), .active_idx_o(active_idx_o),
    .next_idx_o(next_idx_o), .active_preset_upper_word_o(up_w),
    .active_preset_lower_word_o(lo_w), .preset_rd_o(preset_rd_o), .flags_o(flags_o),
    .dir_up_o(dir_up_o), .cmp_out_o(cmp_out_o), .irq_o(irq_o),
    .first_scan_init_pulse_o(first_scan_init_pulse_o));

  initial begin
    core_clk_i = 1'b0;
    forever #10 core_clk_i = ~core_clk_i;
  end

  task automatic give_verdict();
    $display("checks %0d errors %0d", checked, error_cnt);
    if (error_cnt == 0 && checked > 0) $display("DONE - PASS");
    else $display("DONE - FAIL");
    $finish;
  endtask

  task automatic check(input string nm, input logic [31:0] exp, input logic [31:0] got);
    checked++;
    if (got !== exp) begin
      error_cnt++;
      $display("[ERR] %s expected %h seen %h", nm, exp, got);
    end
  endtask

  // returns one cycle after the k-th scan end, outputs settled
  task automatic scan_wait(input int k);
    int n;
    n = 0;
    for (int i = 0; i < k * SCAN + 10 && n < k; i++) begin
      @(posedge core_clk_i);
      if (scan_end_i) n++;
    end
    #1;
    if (n < k) begin
      check("scan wait", 32'(k), 32'(n));
      give_verdict();
    end
  endtask

  task automatic wr_preset(input hsc_idx_t sel, input hsc_cnt_t d);
    @(posedge core_clk_i);
    preset_wr_i <= '{1'b1, sel, d};
    @(posedge core_clk_i);
    preset_wr_i.wr <= 1'b0;
  endtask

  // whole stimulus falls inside one scan
  task automatic run(input hsc_mode_e m, input int kind, input hsc_cnt_t exp);
    @(posedge core_clk_i);
    cfg_i.mode <= m;
    scan_wait(1);
    if (kind == 2) hsc_pulse_src_i.single(1'b0);
    else hsc_pulse_src_i.quad(kind[0]);
    scan_wait(1);
    check("count", exp, count_o);
  endtask

  initial begin
    scan_end_i = 1'b0;
    wait (rstn_i === 1'b1);
    forever begin
      repeat (SCAN - 1) @(posedge core_clk_i);
      scan_end_i <= 1'b1;
      @(posedge core_clk_i);
      scan_end_i <= 1'b0;
    end
  end

  always @(posedge core_clk_i) if (irq_o === 1'b1) irq_cnt <= irq_cnt + 1;

  // each rising match flag consumes the oldest note
  initial begin : watch
    hsc_note_s nt;
    m_prev = 1'b0;
    forever begin
      @(posedge core_clk_i);
      #1;
      mlen = (flags_o.match === 1'b1) ? mlen + 1 : 0;
      if (mlen == SCAN + 1) check("match length", 32'h0, 32'h1);
      if (flags_o.match === 1'b1 && m_prev !== 1'b1) begin
        if (notes.size() == 0) check("stray match", 32'h0, 32'h1);
        else begin
          nt = notes.pop_front();
          check("active idx", 32'(nt.act), 32'(active_idx_o));
          check("next idx", 32'(nt.nxt), 32'(next_idx_o));
          check("count", nt.cnt, count_o);
          check("cmp out", 32'(nt.out), 32'(cmp_out_o));
        end
      end
      m_prev = flags_o.match;
    end
  end

  initial begin : main
    hsc_cnt_t   pv [3];
    hsc_cnt_t   rv;
    logic [7:0] oexp;
    pv = '{32'h3, 32'h2, 32'h4};
    rstn_i = 1'b0;
    clk_en_i = 1'b1;
    cfg_i = '{HSC_ADD, HSC_ACT_OUTPUT, 3'h3, 1'b0, 1'b0, 1'b0, 1'b0};
    ctrl_i = '0;
    reset_value_i = '0;
    preset_wr_i = '0;
    next_wr_i = 1'b0;
    next_data_i = '0;
    preset_rd_sel_i = 3'h1;
    group_clear_input_i = 1'b0;
    repeat (2) @(posedge core_clk_i);
    rstn_i <= 1'b1;
    repeat (5) @(posedge core_clk_i);
    #1 check("init pulse", 32'h1, 32'(first_scan_init_pulse_o));
    for (int k = 0; k < 3; k++) wr_preset(3'(k + 1), pv[k]);
    scan_wait(2);
    check("active idx", 32'h1, 32'(active_idx_o));
    check("next idx", 32'h2, 32'(next_idx_o));
    check("init pulse", 32'h0, 32'(first_scan_init_pulse_o));
    check("active preset", 32'h3, {up_w, lo_w});
    @(posedge core_clk_i);
    ctrl_i.gate <= 1'b1;
    oexp = 8'h00;
    for (int k = 0; k < 4; k++) begin
      oexp[k % 3] = 1'b1;
      notes.push_back('{3'((k + 1) % 3 + 1), 3'((k + 2) % 3 + 1), 32'h0, oexp});
      scan_wait(1);
      repeat (pv[k % 3]) hsc_pulse_src_i.single(1'b0);
      scan_wait(2);
    end
    @(posedge core_clk_i);
    cfg_i.keep <= 1'b1;
    cfg_i.ovf_en <= 1'b1;
    cfg_i.udf_en <= 1'b1;
    wr_preset(3'h2, 32'h1000);
    run(HSC_QUAD4, 0, 32'hfffffffc);
    check("udf flag", 32'h1, 32'(flags_o.udf));
    check("cmp out", 32'h87, 32'(cmp_out_o));
    run(HSC_QUAD4, 1, 32'h0);
    check("ovf flag", 32'h1, 32'(flags_o.ovf));
    check("cmp out", 32'hc7, 32'(cmp_out_o));
    run(HSC_QUAD2, 1, 32'h2);
    run(HSC_QUAD4, 1, 32'h6);
    run(HSC_UPDN, 2, 32'h5);
    check("dir up", 32'h0, 32'(dir_up_o));
    @(posedge core_clk_i);
    ctrl_i.gate <= 1'b0;
    run(HSC_ADD, 2, 32'h5);
    rv = $random(seed) & 32'h0000ffff;
    @(posedge core_clk_i);
    ctrl_i.gate <= 1'b1;
    ctrl_i.out_reset <= 1'b1;
    cfg_i.clear_en <= 1'b1;
    reset_value_i <= rv;
    @(posedge core_clk_i);
    ctrl_i.out_reset <= 1'b0;
    scan_wait(1);
    @(posedge core_clk_i);
    group_clear_input_i <= 1'b1;
    repeat (4) @(posedge core_clk_i);
    group_clear_input_i <= 1'b0;
    scan_wait(1);
    check("count", rv, count_o);
    check("rst flag", 32'h1, 32'(flags_o.rst));
    wr_preset(3'h2, rv + 32'h3);
    @(posedge core_clk_i);
    next_wr_i <= 1'b1;
    next_data_i <= 3'h1;
    preset_rd_sel_i <= 3'h2;
    cfg_i.action <= HSC_ACT_IRQ;
    @(posedge core_clk_i);
    next_wr_i <= 1'b0;
    repeat (2) @(posedge core_clk_i);
    #1 check("preset read", rv + 32'h3, preset_rd_o);
    check("next idx", 32'h1, 32'(next_idx_o));
    notes.push_back('{3'h1, 3'h2, rv + 32'h3, 8'h00});
    scan_wait(1);
    repeat (3) hsc_pulse_src_i.single(1'b0);
    scan_wait(2);
    check("irq pulses", 32'h1, 32'(irq_cnt));
    check("notes left", 32'h0, 32'(notes.size()));
    // enable low freezes the read-back register and holds off the reload
    @(posedge core_clk_i);
    clk_en_i <= 1'b0;
    ctrl_i.sw_reset <= 1'b1;
    reset_value_i <= 32'h5a;
    preset_rd_sel_i <= 3'h3;
    repeat (3) @(posedge core_clk_i);
    #1 check("preset hold", rv + 32'h3, preset_rd_o);
    @(posedge core_clk_i);
    clk_en_i <= 1'b1;
    @(posedge core_clk_i);
    ctrl_i.sw_reset <= 1'b0;
    cfg_i.preset_count <= 3'h1;
    scan_wait(1);
    check("count", 32'h5a, count_o);
    check("rst flag", 32'h0, 32'(flags_o.rst));
    check("preset read", 32'h4, preset_rd_o);
    check("next idx", 32'h1, 32'(next_idx_o));
    give_verdict();
  end
endmodule

`default_nettype wire
